// ---- hdl/cfcu_top.sv ----
// condition flag generation and condition code evaluation
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// RQ1: update flags only when destination is one of the eight extended registers
// RQ2: compare and bit-test instructions always update flags, whatever register
// RQ3: flags sit in status bits 0 to 6: C V Z N UF LV STICKY_UNDERFLOW_FLAG
// RQ4: sticky underflow sets with underflow; cleared only by reset or status write
// RQ5: sticky overflow sets with overflow; cleared only by reset or status write
// RQ6: exponent at or below -128 sets underflow and forces the output to zero
// RQ7: logical ops copy output MSB to negative; arithmetic uses result sign
// RQ8: zero flag set when the output equals zero
// RQ9: overflow on integer misfit or exponent above 127; logical ops clear it
// RQ10: carry from add carry or subtract borrow; cleared other integer; float/logic keep
// RQ11: shifts load carry with last bit out, zero count clears carry
// RQ12: flags judged on float, 32-bit signed or 32-bit unsigned output format
// RQ13: codes 00000 to 10100 accepted; 01011 is undefined and reads false
// RQ14: code 00000 is always true
// RQ15: 00001 C, 00010 C or Z, 00011 not C and not Z, 00100 not C
// RQ16: 00101 is Z, 00110 is not Z
// RQ17: 00111 N, 01000 N or Z, 01001 not N and not Z, 01010 not N
// RQ18: compare-to-zero conditions reuse equal, not-equal, greater, less, greater-equal
// RQ19: 01100 not V, 01101 V, 01110 not UF, 01111 UF
// RQ20: 10000 to 10011 sticky flags and inverses, 10100 Z or UF
// RQ21: explicit status write wins over a same-cycle flag update
module cfcu_top
    import cfcu_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // execution unit result
    input wire cfcu_result_t result,
    // condition query
    input wire logic [4:0] condCode,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    // outputs
    output logic condTrue,
    output logic [31:0] resultOut,
    output cfcu_flags_t flagsOut
);
    cfcu_flags_t flags_q, flags_d, calc;
    logic [31:0] statusUpper_q, statusUpper_d;
    logic [31:0] rdData_q, rdData_d;
    logic condTrue_q, condTrue_d;
    logic [31:0] resultOut_q, resultOut_d;

    // update gating
    wire logic destIsExt = (result.destReg < 5'(DestRegCount)); // RQ1
    wire logic doUpdate = result.valid && (destIsExt || result.isCompare); // RQ1 RQ2
    wire logic isLogic = (result.op == OP_LOGIC);
    wire logic isFloat = (result.op == OP_FLOAT);
    wire logic isIntArith = (result.op == OP_INT_ADD) || (result.op == OP_INT_SUB)
        || (result.op == OP_INT_OTHER);
    wire logic isShift = (result.op == OP_SHIFT);
    wire logic floatUnder = isFloat && (result.exponent <= ExpUnderLimit); // RQ6
    wire logic floatOver = isFloat && (result.exponent > ExpOverLimit); // RQ9 RQ12
    wire logic [31:0] outValue = floatUnder ? 32'h0000_0000 : result.value; // RQ6
    wire logic outZero = (outValue == 32'h0000_0000); // RQ8
    wire logic statusWr = regWr && (regAddr == StatusAddr);

    // flag calculation
    always_comb begin
        calc = flags_q;
        calc.zero = outZero; // RQ8
        calc.underflow = floatUnder; // RQ6
        if (isLogic) begin
            calc.negative = outValue[31]; // RQ7 RQ12
            calc.overflow = 1'b0; // RQ9
        end else if (isFloat) begin
            calc.negative = floatUnder ? 1'b0 : result.floatNegative; // RQ7
            calc.overflow = floatOver; // RQ9
        end else begin
            calc.negative = outValue[31]; // RQ7 RQ12
            calc.overflow = isIntArith && result.intOverflow; // RQ9
        end
        if (result.op == OP_INT_ADD || result.op == OP_INT_SUB) begin
            calc.carry = result.carryOut; // RQ10
        end else if (result.op == OP_INT_OTHER) begin
            calc.carry = 1'b0; // RQ10
        end else if (isShift) begin
            calc.carry = (result.shiftCount == 5'h00) ? 1'b0 : result.shiftLastOut; // RQ11
        end else begin
            calc.carry = flags_q.carry; // RQ10
        end
        calc.stickyOverflow = flags_q.stickyOverflow | calc.overflow; // RQ5
        calc.stickyUnderflow = flags_q.stickyUnderflow | calc.underflow; // RQ4
    end

    // next status
    always_comb begin
        flags_d = flags_q;
        statusUpper_d = statusUpper_q;
        if (statusWr) begin
            flags_d = cfcu_flags_t'(regWrData[FlagCount-1:0]); // RQ21 RQ4 RQ5
            statusUpper_d = regWrData & ~FlagMask;
        end else if (doUpdate) begin
            flags_d = calc; // RQ1 RQ2
        end
    end

    // condition evaluation on the held flags
    always_comb begin
        condTrue_d = 1'b0;
        unique case (cfcu_cond_t'(condCode))
            COND_ALWAYS: condTrue_d = 1'b1; // RQ14
            COND_UNSIGNED_BELOW: condTrue_d = flags_q.carry; // RQ15
            COND_UNSIGNED_BELOW_OR_SAME: condTrue_d = flags_q.carry | flags_q.zero; // RQ15
            COND_UNSIGNED_ABOVE: condTrue_d = ~flags_q.carry & ~flags_q.zero; // RQ15
            COND_UNSIGNED_ABOVE_OR_SAME: condTrue_d = ~flags_q.carry; // RQ15
            COND_EQUAL: condTrue_d = flags_q.zero; // RQ16 RQ18
            COND_NOT_EQUAL: condTrue_d = ~flags_q.zero; // RQ16 RQ18
            COND_SIGNED_LESS: condTrue_d = flags_q.negative; // RQ17 RQ18
            COND_SIGNED_LESS_OR_EQUAL: condTrue_d = flags_q.negative | flags_q.zero; // RQ17
            COND_SIGNED_GREATER: condTrue_d = ~flags_q.negative & ~flags_q.zero; // RQ17 RQ18
            COND_SIGNED_GREATER_OR_EQUAL: condTrue_d = ~flags_q.negative; // RQ17 RQ18
            COND_UNDEFINED: condTrue_d = 1'b0; // RQ13
            COND_NO_OVERFLOW: condTrue_d = ~flags_q.overflow; // RQ19
            COND_OVERFLOW: condTrue_d = flags_q.overflow; // RQ19
            COND_NO_UNDERFLOW: condTrue_d = ~flags_q.underflow; // RQ19
            COND_UNDERFLOW: condTrue_d = flags_q.underflow; // RQ19
            COND_NO_STICKY_OVERFLOW: condTrue_d = ~flags_q.stickyOverflow; // RQ20
            COND_STICKY_OVERFLOW: condTrue_d = flags_q.stickyOverflow; // RQ20
            COND_NO_STICKY_UNDERFLOW: condTrue_d = ~flags_q.stickyUnderflow; // RQ20
            COND_STICKY_UNDERFLOW: condTrue_d = flags_q.stickyUnderflow; // RQ20
            COND_ZERO_OR_UNDERFLOW: condTrue_d = flags_q.zero | flags_q.underflow; // RQ20
            default: condTrue_d = 1'b0; // RQ13
        endcase
    end

    // read data
    wire logic [31:0] statusWord = statusUpper_q | {25'h0, flags_q}; // RQ3
    always_comb begin
        rdData_d = 32'h0000_0000;
        if (regRd) begin
            if (regAddr == StatusAddr) begin
                rdData_d = statusWord; // RQ3
            end else if (regAddr == CondProbeAddr) begin
                rdData_d = {31'h0, condTrue_q};
            end
        end
    end

    assign resultOut_d = result.valid ? outValue : resultOut_q; // RQ6

    always_ff @(posedge clock) begin
        if (srst) begin
            flags_q <= cfcu_flags_t'(StatusReset[FlagCount-1:0]);
            statusUpper_q <= StatusReset;
            rdData_q <= 32'h0000_0000;
            condTrue_q <= 1'b0;
            resultOut_q <= 32'h0000_0000;
        end else begin
            flags_q <= flags_d;
            statusUpper_q <= statusUpper_d;
            rdData_q <= rdData_d;
            condTrue_q <= condTrue_d;
            resultOut_q <= resultOut_d;
        end
    end

    assign regRdData = rdData_q;
    assign condTrue = condTrue_q;
    assign resultOut = resultOut_q;
    assign flagsOut = flags_q;
endmodule

`default_nettype wire

// ---- shared/cfcu_pkg.sv ----
// package for the condition flag and code unit
package cfcu_pkg;
    // status word field positions
    localparam int CarryBit = 0;
    localparam int OverflowBit = 1;
    localparam int ZeroBit = 2;
    localparam int NegativeBit = 3;
    localparam int UnderflowBit = 4;
    localparam int StickyOverflowBit = 5;
    localparam int StickyUnderflowBit = 6;
    localparam int FlagCount = 7;
    localparam logic [31:0] StatusReset = 32'h0000_0000;
    localparam logic [31:0] FlagMask = 32'h0000_007f;
    // register offsets for the plain register port
    localparam logic [3:0] StatusAddr = 4'h0;
    localparam logic [3:0] CondProbeAddr = 4'h1;
    // float exponent limits
    localparam logic signed [9:0] ExpUnderLimit = -10'sd128;
    localparam logic signed [9:0] ExpOverLimit = 10'sd127;
    localparam int DestRegCount = 8;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_LOGIC = 3'b001,
        OP_INT_ADD = 3'b010,
        OP_INT_SUB = 3'b011,
        OP_INT_OTHER = 3'b100,
        OP_FLOAT = 3'b101,
        OP_SHIFT = 3'b110
    } cfcu_op_t;

    typedef enum logic [4:0] {
        COND_ALWAYS = 5'h00,
        COND_UNSIGNED_BELOW = 5'h01,
        COND_UNSIGNED_BELOW_OR_SAME = 5'h02,
        COND_UNSIGNED_ABOVE = 5'h03,
        COND_UNSIGNED_ABOVE_OR_SAME = 5'h04,
        COND_EQUAL = 5'h05,
        COND_NOT_EQUAL = 5'h06,
        COND_SIGNED_LESS = 5'h07,
        COND_SIGNED_LESS_OR_EQUAL = 5'h08,
        COND_SIGNED_GREATER = 5'h09,
        COND_SIGNED_GREATER_OR_EQUAL = 5'h0a,
        COND_UNDEFINED = 5'h0b,
        COND_NO_OVERFLOW = 5'h0c,
        COND_OVERFLOW = 5'h0d,
        COND_NO_UNDERFLOW = 5'h0e,
        COND_UNDERFLOW = 5'h0f,
        COND_NO_STICKY_OVERFLOW = 5'h10,
        COND_STICKY_OVERFLOW = 5'h11,
        COND_NO_STICKY_UNDERFLOW = 5'h12,
        COND_STICKY_UNDERFLOW = 5'h13,
        COND_ZERO_OR_UNDERFLOW = 5'h14
    } cfcu_cond_t;

    // result presented by an execution unit
    typedef struct packed {
        logic valid;
        cfcu_op_t op;
        logic isCompare;
        logic [4:0] destReg;
        logic [31:0] value;
        logic carryOut;
        logic intOverflow;
        logic signed [9:0] exponent;
        logic floatNegative;
        logic [4:0] shiftCount;
        logic shiftLastOut;
    } cfcu_result_t;

    // flags as held in the status word
    typedef struct packed {
        logic stickyUnderflow;
        logic stickyOverflow;
        logic underflow;
        logic negative;
        logic zero;
        logic overflow;
        logic carry;
    } cfcu_flags_t;
endpackage

// ---- verif/cfcu_properties.sv ----
// assertions on the ports of the condition flag unit
`timescale 1ns/1ps
`default_nettype none
module cfcu_properties
    import cfcu_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // unit inputs
    input wire cfcu_result_t result,
    input wire logic [4:0] condCode,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    // unit outputs
    input wire logic [31:0] regRdData,
    input wire logic condTrue,
    input wire logic [31:0] resultOut,
    input wire cfcu_flags_t flagsOut
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    wire logic stWr = regWr && regAddr == StatusAddr;
    wire logic upd = result.valid && !stWr && (result.destReg < 5'h8 || result.isCompare);
    a_addr_dest_skip: assert property (result.valid && !result.isCompare && result.destReg > 5'h7 && !stWr |=> $stable(flagsOut)) else $error("flags moved");
    a_compare_updates: assert property (upd && result.isCompare && result.op == OP_INT_SUB |=> flagsOut.carry == $past(result.carryOut)) else $error("compare carry");
    a_status_read: assert property (regRd && regAddr == StatusAddr |=> regRdData[6:0] == $past(flagsOut)) else $error("status read");
    a_read_idle: assert property (!$past(regRd) |-> regRdData == 32'h0) else $error("read data idle");
    a_sticky_under: assert property (upd && result.op == OP_FLOAT && result.exponent <= ExpUnderLimit |=> flagsOut.underflow && flagsOut.stickyUnderflow && resultOut == 32'h0) else $error("underflow");
    a_sticky_hold: assert property (flagsOut.stickyOverflow && !stWr |=> flagsOut.stickyOverflow) else $error("sticky lost");
    a_float_over: assert property (upd && result.op == OP_FLOAT && result.exponent > ExpOverLimit |=> flagsOut.overflow && flagsOut.stickyOverflow) else $error("overflow");
    a_logic_flags: assert property (upd && result.op == OP_LOGIC |=> flagsOut.zero == ($past(result.value) == 32'h0) && !flagsOut.overflow && flagsOut.negative == $past(result.value[31])) else $error("logic flags");
    a_float_carry: assert property (upd && result.op == OP_FLOAT |=> $stable(flagsOut.carry)) else $error("float carry");
    a_shift_carry: assert property (upd && result.op == OP_SHIFT |=> flagsOut.carry == ($past(result.shiftCount) != 5'h0 && $past(result.shiftLastOut))) else $error("shift carry");
    a_write_wins: assert property (stWr |=> flagsOut == $past(regWrData[6:0])) else $error("status write");
    a_always_true: assert property (condCode == COND_ALWAYS |=> condTrue) else $error("always code");
    a_undef_false: assert property (condCode == COND_UNDEFINED |=> !condTrue) else $error("undefined code");
endmodule
bind cfcu_top cfcu_properties chk (.clock(clock), .srst(srst), .result(result), .condCode(condCode),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .condTrue(condTrue), .resultOut(resultOut), .flagsOut(flagsOut));
`default_nettype wire

// ---- verif/cfcu_exec_model.sv ----
// execution unit model presenting one result per issue
`timescale 1ns/1ps
`default_nettype none
module cfcu_exec_model
    import cfcu_pkg::*;
(
    // clock
    input wire logic clock,
    // issue request
    input wire logic issue,
    input wire cfcu_op_t op,
    input wire logic [4:0] dest,
    input wire logic cmp,
    input wire logic [31:0] a,
    input wire logic [31:0] b,
    input wire logic signed [9:0] expIn,
    // result to the unit
    output cfcu_result_t res
);
    logic [32:0] sum;
    assign sum = (op == OP_INT_SUB) ? {1'h0, a} - {1'h0, b} : {1'h0, a} + {1'h0, b};
    initial res = '0;
    always @(posedge clock) begin
        res <= ~res;
        res.valid <= issue;
        if (issue) begin
            res.op <= op;
            res.isCompare <= cmp;
            res.destReg <= dest;
            res.value <= (op == OP_LOGIC) ? a ^ b : (op == OP_SHIFT) ? a << b[4:0] :
                (op == OP_FLOAT || op == OP_INT_OTHER) ? a : sum[31:0];
            res.carryOut <= sum[32];
            res.intOverflow <= op == OP_INT_ADD && a[31] == b[31] && sum[31] != a[31];
            res.exponent <= expIn;
            res.floatNegative <= a[31];
            res.shiftCount <= b[4:0];
            res.shiftLastOut <= b[4:0] != 5'h0 && a[5'h0 - b[4:0]];
        end
    end
endmodule
`default_nettype wire

// ---- verif/cfcu_top_tb.sv ----
// self-checking bench for the condition flag unit
`timescale 1ns/1ps
`default_nettype none
module cfcu_top_tb;
    import cfcu_pkg::*;
    typedef struct packed {cfcu_op_t op; logic [4:0] d; logic c; logic [31:0] a; logic [31:0] b; logic [9:0] e; logic [6:0] f;} cfcu_step_t;
    logic clock = '0, srst = 1'h1, regWr = '0, regRd = '0, issue = '0, cmp = '0, rdPend = '0, condTrue;
    logic [2:0] opBits = '0;
    logic [3:0] regAddr = '0;
    logic [4:0] condCode = '0, dest = '0;
    logic [31:0] regWrData = '0, a = '0, b = '0, regRdData, resultOut, rng = 32'h8295;
    logic signed [9:0] expIn = '0;
    cfcu_result_t res;
    cfcu_flags_t flagsOut;
    logic [31:0] expQ[$];
    int n_fail = 0, check_count = 0;
    cfcu_step_t steps[10] = '{
        '{OP_INT_ADD, 5'h0, 1'h0, 32'hffffffff, 32'h1, 10'h0, 7'h05}, '{OP_INT_ADD, 5'h8, 1'h0, 32'h1, 32'h1, 10'h0, 7'h05},
        '{OP_INT_SUB, 5'h9, 1'h1, 32'h0, 32'h1, 10'h0, 7'h09}, '{OP_FLOAT, 5'h1, 1'h0, 32'h5, 32'h0, 10'h380, 7'h55},
        '{OP_FLOAT, 5'h1, 1'h0, 32'h80000000, 32'h0, 10'h080, 7'h6b}, '{OP_LOGIC, 5'h2, 1'h0, 32'h80000000, 32'h0, 10'h0, 7'h69},
        '{OP_SHIFT, 5'h3, 1'h0, 32'h1, 32'h0, 10'h0, 7'h60}, '{OP_SHIFT, 5'h3, 1'h0, 32'h80000000, 32'h1, 10'h0, 7'h65},
        '{OP_INT_OTHER, 5'h4, 1'h0, 32'h7fffffff, 32'h0, 10'h0, 7'h60}, '{OP_INT_ADD, 5'h5, 1'h0, 32'h7fffffff, 32'h1, 10'h0, 7'h6a}};
    always #5 clock = ~clock;
    cfcu_exec_model model (.clock(clock), .issue(issue), .op(cfcu_op_t'(opBits)), .dest(dest), .cmp(cmp), .a(a), .b(b), .expIn(expIn), .res(res));
    cfcu_top dut (.clock(clock), .srst(srst), .result(res), .condCode(condCode), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .condTrue(condTrue), .resultOut(resultOut), .flagsOut(flagsOut));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic cond(input logic [4:0] k, input logic [6:0] f);
        logic [31:0] t;
        t = {11'h0, f[2] | f[4], f[6], ~f[6], f[5], ~f[5], f[4], ~f[4], f[1], ~f[1], 1'h0, ~f[3], ~f[3] & ~f[2], f[3] | f[2],
            f[3], ~f[2], f[2], ~f[0], ~f[0] & ~f[2], f[0] | f[2], f[0], 1'h1};
        return t[k];
    endfunction
    task automatic rd(input logic [3:0] ad, input logic [31:0] ev);
        regAddr <= ad;
        regRd <= 1'h1;
        expQ.push_back(ev);
        @(posedge clock);
        regRd <= 1'h0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [3:0] ad, input logic [31:0] d, input logic go);
        regAddr <= ad;
        regWrData <= d;
        issue <= go;
        @(posedge clock);
        regWr <= 1'h1;
        issue <= 1'h0;
        @(posedge clock);
        regWr <= 1'h0;
        @(posedge clock);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        if (rdPend) begin
            check_count++;
            if (regRdData !== expQ[0]) begin
                n_fail++;
                $display("CHECK FAILED t=%0t read %h expected %h", $time, regRdData, expQ[0]);
            end
            void'(expQ.pop_front());
        end
        rdPend <= regRd;
    end
    initial begin
        #20us;
        n_fail++;
        complete_run;
    end
    initial begin
        repeat (16) @(posedge clock);
        srst <= 1'h0;
        @(posedge clock);
        rd(StatusAddr, 32'h0);
        wr(4'h7, 32'hffffffff, 1'h0);
        rd(4'h7, 32'h0);
        rd(StatusAddr, 32'h0);
        $display("register port test done");
        foreach (steps[i]) begin
            {opBits, dest, cmp, a, b, expIn} <= steps[i][89:7];
            issue <= 1'h1;
            @(posedge clock);
            issue <= 1'h0;
            repeat (2) @(posedge clock);
            rd(StatusAddr, {25'h0, steps[i].f});
        end
        $display("flag update test done");
        {opBits, dest, cmp, a, b, expIn} <= steps[0][89:7];
        wr(StatusAddr, 32'h0, 1'h1);
        rd(StatusAddr, 32'h0);
        $display("write precedence test done");
        for (int r = 0; r < 4; r++) begin
            rng = xs(rng);
            wr(StatusAddr, rng, 1'h0);
            rd(StatusAddr, rng);
            for (int c = 0; c < 32; c++) begin
                condCode <= c[4:0];
                @(posedge clock);
                rd(CondProbeAddr, {31'h0, cond(c[4:0], rng[6:0])});
            end
        end
        $display("condition code test done");
        repeat (3) @(posedge clock);
        complete_run;
    end
endmodule
`default_nettype wire
